// File: rtl/jrtl_pkg.sv
// Notes on behaviour
// - Frames per processing cycle equal four over F.
// - Processing clock is a quarter of byte rate.
// - Per-link measured latency readable in processing cycles.
// - Frame octets mapped to samples by link parameters; the code maps octet pairs high byte first, the same in every mode.
// - F limited to one, two or four.
// - K is 32 when F is one.
// - Lane count limited per single or dual link.
// - Converter and sample counts limited per link mode.
// - Control words and control bits must be zero.
// - High density exactly when F equals one.
// - Resolution and bits per sample fixed at sixteen.
// - Single-link modes zero to ten except eight.
// - Dual-link supports modes four to ten except eight.
// - Local multiframe clock delayed per link by offset.
// - Variation acts as receive buffer delay; the code uses only the link A variation, for both links.
// - Buffer delay accepts zero to ten cycles.
package jrtl_pkg;
    localparam logic [11:0] JRTL_OFS_LAT0   = 12'h302;
    localparam logic [11:0] JRTL_OFS_LAT1   = 12'h303;
    localparam logic [11:0] JRTL_OFS_MFO_A  = 12'h304;
    localparam logic [11:0] JRTL_OFS_MFO_B  = 12'h305;
    localparam logic [11:0] JRTL_OFS_VAR_A  = 12'h306;
    localparam logic [11:0] JRTL_OFS_VAR_B  = 12'h307;
    localparam logic [7:0]  JRTL_RST_REG    = 8'h00;
    localparam logic [3:0]  JRTL_MAX_VAR    = 4'hA;
    localparam logic [5:0]  JRTL_K_SMALL    = 6'h10;
    localparam logic [5:0]  JRTL_K_LARGE    = 6'h20;
    localparam logic [4:0]  JRTL_NBITS      = 5'h10;
    localparam int          JRTL_OCTETS     = 4;
    localparam int          JRTL_BUF_DEPTH  = 11;
    localparam real         JRTL_CLK_NS     = 50.0;
    typedef enum logic [1:0] {JRTL_ILAS, JRTL_DATA} jrtl_phase_type;
endpackage

// File: rtl/jrtl_mode_check.sv
`timescale 1ns/1ps
// Decodes the link parameters and flags unsupported combinations.
module jrtl_mode_check
    import jrtl_pkg::*;
(
    input  wire logic       dual_link,
    input  wire logic [3:0] lanes,
    input  wire logic [2:0] converters,
    input  wire logic [1:0] samples,
    input  wire logic [2:0] octets,
    input  wire logic [5:0] frames_per_mf,
    input  wire logic       high_density,
    input  wire logic [4:0] ctrl_words,
    input  wire logic [1:0] ctrl_bits,
    input  wire logic [4:0] resolution,
    input  wire logic [4:0] sample_bits,
    output logic            mode_ok,
    output logic [2:0]      frames_per_proc_cycle
);
    logic combo_ok;
    logic k_ok;

    // Mode table lookup on M/L/S/F.
    always_comb begin
        combo_ok = 1'b0;
        case ({converters, lanes, samples, octets})
            {3'd4,4'd8,2'd1,3'd1}, {3'd4,4'd8,2'd2,3'd2},
            {3'd4,4'd4,2'd1,3'd2}, {3'd4,4'd2,2'd1,3'd4}: begin
                combo_ok = !dual_link;
            end
            {3'd2,4'd4,2'd1,3'd1}, {3'd2,4'd4,2'd2,3'd2},
            {3'd2,4'd2,2'd1,3'd2}, {3'd2,4'd1,2'd1,3'd4},
            {3'd1,4'd2,2'd1,3'd1}, {3'd1,4'd1,2'd1,3'd2}: begin
                combo_ok = 1'b1;
            end
            default: begin
                combo_ok = 1'b0;
            end
        endcase
    end

    // K is fixed at 32 for single-octet frames.
    assign k_ok = (octets == 3'd1) ? (frames_per_mf == JRTL_K_LARGE)
                : (frames_per_mf == JRTL_K_LARGE ||
                   frames_per_mf == JRTL_K_SMALL);

    assign mode_ok = combo_ok && k_ok
                   && (high_density == (octets == 3'd1))
                   && (ctrl_words == 5'h00) && (ctrl_bits == 2'h0)
                   && (resolution == JRTL_NBITS)
                   && (sample_bits == JRTL_NBITS);

    // Frame clocks per processing cycle.
    assign frames_per_proc_cycle = (octets == 3'd1) ? 3'd4
                                 : (octets == 3'd2) ? 3'd2 : 3'd1;
endmodule // jrtl_mode_check

// File: rtl/jrtl_transport.sv
`timescale 1ns/1ps
// Receive transport layer: one link of lane octets in, 16-bit samples out.
// Each processing cycle carries four octets per lane (quarter byte rate).
module jrtl_transport
    import jrtl_pkg::*;
#(
    parameter int LANES = 8
)(
    input  wire logic                 clock,
    input  wire logic                 nrst,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [11:0]          reg_addr,
    input  wire logic [7:0]           reg_wdata,
    output logic [7:0]                reg_rdata,
    input  wire logic                 dual_link,
    input  wire logic [3:0]           lanes,
    input  wire logic [2:0]           converters,
    input  wire logic [1:0]           samples,
    input  wire logic [2:0]           octets,
    input  wire logic [5:0]           frames_per_mf,
    input  wire logic                 high_density,
    input  wire logic [4:0]           ctrl_words,
    input  wire logic [1:0]           ctrl_bits,
    input  wire logic [4:0]           resolution,
    input  wire logic [4:0]           sample_bits,
    input  wire logic [1:0]           sysref_mf_start,
    input  wire logic [1:0]           ilas_end,
    input  wire logic                 in_valid,
    input  wire logic [LANES*32-1:0]  in_octets,
    output logic                      mode_ok,
    output logic                      out_valid,
    output logic [LANES*32-1:0]       out_samples
);
    logic [7:0] lat0_q, lat0_d, lat1_q, lat1_d;
    logic [7:0] mfo_a_q, mfo_a_d, mfo_b_q, mfo_b_d;
    logic [7:0] var_a_q, var_a_d, var_b_q, var_b_d;
    logic [2:0] fppc;
    logic [3:0] var_eff;
    logic [5:0] ppmf;
    logic [5:0] mf_cnt_q [2];
    logic [5:0] mf_cnt_d [2];
    logic [5:0] dly_cnt_q [2];
    logic [5:0] dly_cnt_d [2];
    logic [1:0] dly_run_q, dly_run_d;
    logic [1:0] lmfc;
    logic [7:0] rel_cnt_q, rel_cnt_d;
    logic       rel_pend_q, rel_pend_d;
    logic       release_q, release_d;
    logic [LANES*32-1:0] buf_q [JRTL_BUF_DEPTH];
    logic [JRTL_BUF_DEPTH-1:0] bval_q;
    logic [LANES*32-1:0] mapped;
    logic [LANES*32-1:0] out_q, out_d;
    logic       outv_q, outv_d;

    jrtl_mode_check u_check (
        .dual_link             (dual_link),
        .lanes                 (lanes),
        .converters            (converters),
        .samples               (samples),
        .octets                (octets),
        .frames_per_mf         (frames_per_mf),
        .high_density          (high_density),
        .ctrl_words            (ctrl_words),
        .ctrl_bits             (ctrl_bits),
        .resolution            (resolution),
        .sample_bits           (sample_bits),
        .mode_ok               (mode_ok),
        .frames_per_proc_cycle (fppc)
    );

    // Processing cycles per multiframe is K divided by the frame ratio.
    assign ppmf = (fppc == 3'd4) ? (frames_per_mf >> 2)
                : (fppc == 3'd2) ? (frames_per_mf >> 1) : frames_per_mf;

    // Buffer delay clipped to its legal range.
    assign var_eff = (var_a_q > {4'h0, JRTL_MAX_VAR}) ? JRTL_MAX_VAR
                   : var_a_q[3:0];

    // Register writes and the two per-link latency captures.
    always_comb begin
        mfo_a_d = mfo_a_q;
        mfo_b_d = mfo_b_q;
        var_a_d = var_a_q;
        var_b_d = var_b_q;
        lat0_d  = lat0_q;
        lat1_d  = lat1_q;
        if (reg_wr) begin
            case (reg_addr)
                JRTL_OFS_MFO_A: mfo_a_d = reg_wdata;
                JRTL_OFS_MFO_B: mfo_b_d = reg_wdata;
                JRTL_OFS_VAR_A: var_a_d = reg_wdata;
                JRTL_OFS_VAR_B: var_b_d = reg_wdata;
                default: begin
                end
            endcase
        end
        // Latency from local multiframe start to first data sample.
        if (ilas_end[0]) begin
            lat0_d = {2'b00, mf_cnt_q[0]};
        end
        if (ilas_end[1]) begin
            lat1_d = {2'b00, mf_cnt_q[1]};
        end
    end

    // Read mux; unmapped addresses read zero.
    always_comb begin
        reg_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                JRTL_OFS_LAT0:  reg_rdata = lat0_q;
                JRTL_OFS_LAT1:  reg_rdata = lat1_q;
                JRTL_OFS_MFO_A: reg_rdata = mfo_a_q;
                JRTL_OFS_MFO_B: reg_rdata = mfo_b_q;
                JRTL_OFS_VAR_A: reg_rdata = var_a_q;
                JRTL_OFS_VAR_B: reg_rdata = var_b_q;
                default:        reg_rdata = 8'h00;
            endcase
        end
    end

    // Per-link local multiframe clock: the aligned boundary starts a delay
    // count of offset/ratio cycles, after which the local boundary fires.
    for (genvar l = 0; l < 2; l++) begin : g_link
        logic [7:0] dly_target;
        assign dly_target = (l == 0 ? mfo_a_q : mfo_b_q) >> (fppc >> 1);
        assign lmfc[l] = dly_run_q[l] &&
                         ({2'b00, dly_cnt_q[l]} == dly_target);
        always_comb begin
            dly_run_d[l] = dly_run_q[l];
            dly_cnt_d[l] = dly_cnt_q[l];
            mf_cnt_d[l]  = mf_cnt_q[l] + 6'd1;
            if (mf_cnt_d[l] >= ppmf) begin
                mf_cnt_d[l] = 6'd0;
            end
            if (sysref_mf_start[l]) begin
                dly_run_d[l] = 1'b1;
                dly_cnt_d[l] = 6'd0;
            end else if (lmfc[l]) begin
                dly_run_d[l] = 1'b0;
            end else if (dly_run_q[l]) begin
                dly_cnt_d[l] = dly_cnt_q[l] + 6'd1;
            end
            if (lmfc[l]) begin
                mf_cnt_d[l] = 6'd0;
            end
        end
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                mf_cnt_q[l]  <= 6'd0;
                dly_cnt_q[l] <= 6'd0;
                dly_run_q[l] <= 1'b0;
            end else begin
                mf_cnt_q[l]  <= mf_cnt_d[l];
                dly_cnt_q[l] <= dly_cnt_d[l];
                dly_run_q[l] <= dly_run_d[l];
            end
        end
    end

    // Release at link 0 boundary plus buffer delay, shared by both links.
    always_comb begin
        rel_cnt_d  = rel_cnt_q;
        rel_pend_d = rel_pend_q;
        release_d  = release_q;
        if (lmfc[0] && !release_q) begin
            rel_pend_d = 1'b1;
            rel_cnt_d  = 8'h00;
        end else if (rel_pend_q) begin
            if (rel_cnt_q[3:0] == var_eff) begin
                rel_pend_d = 1'b0;
                release_d  = 1'b1;
            end else begin
                rel_cnt_d = rel_cnt_q + 8'h01;
            end
        end
        if (!mode_ok) begin
            release_d = 1'b0;
        end
    end

    // Octet to sample mapping: high byte first, pairs of octets per sample.
    for (genvar s = 0; s < LANES*2; s++) begin : g_map
        assign mapped[s*16 +: 16] = {in_octets[s*16 +: 8],
                                     in_octets[s*16+8 +: 8]};
    end

    // Receive buffer: a shift line whose tap is the buffer delay.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bval_q <= '0;
            for (int i = 0; i < JRTL_BUF_DEPTH; i++) begin
                buf_q[i] <= '0;
            end
        end else begin
            bval_q <= {bval_q[JRTL_BUF_DEPTH-2:0], in_valid};
            buf_q[0] <= mapped;
            for (int i = 1; i < JRTL_BUF_DEPTH; i++) begin
                buf_q[i] <= buf_q[i-1];
            end
        end
    end

    // Output stage holds data only once the release has fired.
    always_comb begin
        out_d  = out_q;
        outv_d = 1'b0;
        if (release_q && bval_q[var_eff]) begin
            out_d  = buf_q[var_eff];
            outv_d = 1'b1;
        end
    end

    // Register state update.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mfo_a_q    <= JRTL_RST_REG;
            mfo_b_q    <= JRTL_RST_REG;
            var_a_q    <= JRTL_RST_REG;
            var_b_q    <= JRTL_RST_REG;
            lat0_q     <= JRTL_RST_REG;
            lat1_q     <= JRTL_RST_REG;
            rel_cnt_q  <= 8'h00;
            rel_pend_q <= 1'b0;
            release_q  <= 1'b0;
            out_q      <= '0;
            outv_q     <= 1'b0;
        end else begin
            mfo_a_q    <= mfo_a_d;
            mfo_b_q    <= mfo_b_d;
            var_a_q    <= var_a_d;
            var_b_q    <= var_b_d;
            lat0_q     <= lat0_d;
            lat1_q     <= lat1_d;
            rel_cnt_q  <= rel_cnt_d;
            rel_pend_q <= rel_pend_d;
            release_q  <= release_d;
            out_q      <= out_d;
            outv_q     <= outv_d;
        end
    end

    assign out_valid   = outv_q;
    assign out_samples = out_q;
endmodule // jrtl_transport

// File: testbench/jrtl_asserts.sv
`timescale 1ns/1ps
// Watches the register port and the mode decoder.
module jrtl_asserts
    import jrtl_pkg::*;
(
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        dual_link,
    input wire logic [3:0]  lanes,
    input wire logic [2:0]  converters,
    input wire logic [2:0]  octets,
    input wire logic [5:0]  frames_per_mf,
    input wire logic        high_density,
    input wire logic [4:0]  ctrl_words,
    input wire logic [4:0]  resolution,
    input wire logic        mode_ok
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // Illegal parameter values must never pass the decoder.
    a_f_three_bad: assert property (octets == 3'h3 |-> !mode_ok)
        else $error("octet count of three accepted");
    a_k_small_bad: assert property (octets == 3'h1 &&
        frames_per_mf != JRTL_K_LARGE |-> !mode_ok)
        else $error("short multiframe accepted with one octet");
    a_dual_lanes: assert property (dual_link && lanes == 4'h8 |-> !mode_ok)
        else $error("eight lanes accepted on a dual link");
    a_dual_conv: assert property (dual_link && converters == 3'h4
        |-> !mode_ok) else $error("four converters on a dual link");
    a_ctrl_zero: assert property (ctrl_words != 5'h00 |-> !mode_ok)
        else $error("control words accepted");
    a_hd_match: assert property (high_density != (octets == 3'h1)
        |-> !mode_ok) else $error("density flag mismatch accepted");
    a_res_fixed: assert property (resolution != JRTL_NBITS |-> !mode_ok)
        else $error("resolution other than sixteen accepted");
    // A written offset reads back on the next cycle.
    a_offset_back: assert property (reg_wr && reg_addr == JRTL_OFS_MFO_A
        ##1 reg_rd && reg_addr == JRTL_OFS_MFO_A |->
        reg_rdata == $past(reg_wdata)) else $error("offset not stored");
endmodule // jrtl_asserts

// File: testbench/jrtl_tx_model.sv
`timescale 1ns/1ps
// Far-side transmitter: sync pulses, alignment end and lane data.
module jrtl_tx_model (
    input  wire logic  clock,
    output logic [1:0] sysref_mf_start,
    output logic [1:0] ilas_end,
    output logic       in_valid,
    output logic [31:0] in_octets
);
    // Lines start quiet.
    initial begin
        sysref_mf_start = 2'h0;
        ilas_end = 2'h0;
        in_valid = 1'h0;
        in_octets = 32'h0;
    end
    // Sync on both links, then alignment end gap cycles later.
    task automatic sync(input int gap);
        @(negedge clock) sysref_mf_start = 2'h3;
        @(negedge clock) sysref_mf_start = 2'h0;
        repeat (gap - 1) @(negedge clock);
        ilas_end = 2'h3;
        @(negedge clock) ilas_end = 2'h0;
    endtask
    // Four octets per lane per cycle; released lines flip.
    task automatic word(input logic [31:0] d);
        @(negedge clock) in_valid = 1'h1;
        in_octets = d;
        @(negedge clock) in_valid = 1'h0;
        in_octets = ~d;
    endtask
endmodule // jrtl_tx_model

// File: testbench/jrtl_transport_bench.sv
`timescale 1ns/1ps
module jrtl_transport_bench;
    import jrtl_pkg::*;
    logic clock = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [11:0] reg_addr = 12'h0;
    logic [7:0]  reg_wdata = 8'h0, reg_rdata, a, b;
    logic dual_link = 1'h0, high_density = 1'h1, mode_ok, out_valid;
    logic [3:0]  lanes = 4'h4;
    logic [2:0]  converters = 3'h2, octets = 3'h1;
    logic [1:0]  samples = 2'h1, ctrl_bits = 2'h0, sy, il;
    logic [5:0]  frames_per_mf = 6'h20;
    logic [4:0]  ctrl_words = 5'h0, resolution = 5'h10, sample_bits = 5'h10;
    logic [31:0] in_octets, out_samples;
    logic        in_valid;
    logic [15:0] mt [10] = '{16'h4811, 16'h4822, 16'h4412, 16'h4214,
        16'h2411, 16'h2422, 16'h2212, 16'h2114, 16'h1211, 16'h1112};
    int error_cnt = 0, checked = 0, cyc = 0, n;
    always #25 clock = ~clock;
    jrtl_tx_model tx (.clock, .sysref_mf_start(sy), .ilas_end(il),
        .in_valid, .in_octets);
    jrtl_transport #(.LANES(1)) dut (.clock, .nrst, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .dual_link, .lanes, .converters,
        .samples, .octets, .frames_per_mf, .high_density, .ctrl_words,
        .ctrl_bits, .resolution, .sample_bits, .sysref_mf_start(sy),
        .ilas_end(il), .in_valid, .in_octets, .mode_ok, .out_valid,
        .out_samples);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] ad, input logic [7:0] d);
        @(negedge clock) reg_wr = 1'h1;
        reg_addr = ad;
        reg_wdata = d;
        @(negedge clock) reg_wr = 1'h0;
    endtask
    task automatic rd(input logic [11:0] ad, output logic [7:0] d);
        @(negedge clock) reg_rd = 1'h1;
        reg_addr = ad;
        @(posedge clock) d = reg_rdata;
        @(negedge clock) reg_rd = 1'h0;
    endtask
    // Write then read back on the very next edge; idle read data is zero.
    task automatic wr_rd(input logic [11:0] ad, input logic [7:0] d);
        @(negedge clock) reg_wr = 1'h1;
        reg_addr = ad;
        reg_wdata = d;
        @(negedge clock) reg_wr = 1'h0;
        reg_rd = 1'h1;
        @(posedge clock) chk(reg_rdata, d);
        @(negedge clock) reg_rd = 1'h0;
        #1 chk(reg_rdata, 8'h00);
    endtask
    task automatic set_mode(input logic dl, input logic [15:0] p);
        @(negedge clock) dual_link = dl;
        converters = p[14:12];
        lanes = p[11:8];
        samples = p[5:4];
        octets = p[2:0];
        high_density = p[3:0] == 4'h1;
        frames_per_mf = 6'h20;
        #1 chk(mode_ok, 1'h1);
    endtask
    // Reset values, read-only latency and stored settings.
    task automatic test_regs();
        for (int i = 2; i < 8; i++) begin
            rd(12'h300 + i, a);
            chk(a, JRTL_RST_REG);
        end
        wr(JRTL_OFS_LAT0, 8'h5A);
        rd(JRTL_OFS_LAT0, a);
        chk(a, 8'h00);
        wr_rd(JRTL_OFS_MFO_A, 8'hA5);
        for (int i = 4; i < 8; i++) wr(12'h300 + i, 8'h10 + i);
        for (int i = 4; i < 8; i++) begin
            rd(12'h300 + i, a);
            chk(a, 8'h10 + i);
        end
        rd(12'h308, a);
        chk(a, 8'h00);
    endtask
    // Every listed mode decodes; broken variants are refused.
    task automatic test_modes();
        for (int i = 0; i < 10; i++) set_mode(1'h0, mt[i]);
        for (int i = 4; i < 10; i++) set_mode(1'h1, mt[i]);
        @(negedge clock) lanes = 4'h8;
        #1 chk(mode_ok, 1'h0);
        set_mode(1'h0, mt[4]);
        @(negedge clock) frames_per_mf = 6'h10;
        #1 chk(mode_ok, 1'h0);
        set_mode(1'h0, mt[4]);
        // Each illegal field on its own, then dual link with four converters, must drop the mode flag.
        for (int k = 0; k < 6; k++) begin
            @(negedge clock) case (k)
                0: octets = 3'h3;
                1: ctrl_words = 5'h01;
                2: ctrl_bits = 2'h1;
                3: high_density = 1'h0;
                4: resolution = 5'h0F;
                default: {dual_link, converters} = 4'hC;
            endcase
            #1 chk(mode_ok, 1'h0);
            ctrl_words = 5'h00;
            ctrl_bits = 2'h0;
            resolution = 5'h10;
            set_mode(1'h0, mt[4]);
        end
    endtask
    // Latency with zero offset follows the alignment end time.
    task automatic test_latency();
        wr(JRTL_OFS_MFO_A, 8'h00);
        wr(JRTL_OFS_MFO_B, 8'h00);
        tx.sync(2);
        rd(JRTL_OFS_LAT0, a);
        tx.sync(5);
        rd(JRTL_OFS_LAT0, b);
        chk(b - a, 8'h03);
        rd(JRTL_OFS_LAT1, a);
        chk(a, b);
    endtask
    // Release delay per variation, clipped at ten, and octet order.
    task automatic test_release();
        logic [7:0] v [4] = '{8'h00, 8'h03, 8'h0F, 8'h00};
        int lo = int'($floor(3.5));
        int hi = int'($ceil(4.5));
        // Last setting is derived from the two bounding delays.
        v[3] = 8'((hi + 1) - (lo - 1));
        for (int i = 0; i < 4; i++) begin
            wr(JRTL_OFS_VAR_A, v[i]);
            wr(JRTL_OFS_VAR_B, v[i]);
            // Four frames per cycle at one octet per frame, K of 32.
            wr(JRTL_OFS_MFO_A, 8'(((lo - 1) * 4) % 32));
            wr(JRTL_OFS_MFO_B, 8'(((lo - 1) * 4) % 32));
            tx.sync(2);
            repeat (16) @(negedge clock);
            tx.word(32'h44332211);
            n = 0;
            while (out_valid !== 1'h1 && n < 30) begin
                @(negedge clock);
                n++;
            end
            chk(n, (v[i] > 10 ? 10 : v[i]) + 1);
            chk(out_samples, 32'h33441122);
            @(negedge clock) chk(out_valid, 1'h0);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial begin
        repeat (3) @(negedge clock);
        nrst = 1'h1;
        test_regs();
        test_modes();
        test_latency();
        test_release();
        report_and_stop();
    end
endmodule // jrtl_transport_bench
bind jrtl_transport jrtl_asserts chk_i (.clock, .nrst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .dual_link, .lanes, .converters,
    .octets, .frames_per_mf, .high_density, .ctrl_words, .resolution,
    .mode_ok);
